// File: rtl/sadc_top.sv
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
// How it works
// - The conversion clock is the system clock divided by one of four ratios.
// - Divide select code 10 in config bits 5:4 gives a ratio of 8.
// - A conversion lasts 15 approximation clocks, 1 sync clock and the acquisition time.
// - Acquisition time is 1 to 4 conversion clocks, set by config bits 3:2.
// - In continuous mode a new conversion starts on the same conversion clock tick on which one ends.
// - Config bit 6 set selects the external reference on the reference pin.
// - The internal reference stays off after reset until software enables it.
// - Channel register bit 6 enables direct-to-memory mode.
// - Direct-to-memory writes results to a 24-bit address space without the core.
// - Each result is written as its own conversion ends; the results of the first two conversions are not written.
// - The done flag is set by hardware when the memory stream reaches its stop code.
// - The pipeline writes its first correct result after three conversion cycles.
module sadc_top (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [sadc_pkg::SADC_AW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [11:0] adc_result_i,
  output logic adc_sample_o,
  output logic adc_power_o,
  output logic [3:0] adc_channel_o,
  output logic ref_ext_sel_o,
  output logic ref_int_en_o,
  output logic [23:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  output logic mem_write_o,
  output logic mem_read_o,
  input wire logic [15:0] mem_rdata_i,
  output logic done_flag_o
);
  import sadc_pkg::*;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] chn;
    logic [23:0] dma_ptr;
    logic [31:0] rdata;
    logic ack;
    sadc_phase_t phase;
    logic [4:0] cnt;
    logic done;
    logic [11:0] result;
    logic result_vld;
    logic [3:0] conv_id;
    logic [3:0] next_id;
    logic [3:0] wr_id;
    logic [1:0] pipe;
    logic dma_act;
    logic stopping;
    logic [23:0] mem_addr;
    logic [15:0] mem_wdata;
    logic mem_we;
    logic mem_re;
    logic sample;
    logic [23:0] rd_addr;
    logic [23:0] mem_bus;
    logic [3:0] chan;
    logic int_ref;
    logic wreq;
  } sadc_st_t;

  sadc_st_t st_q, st_d;
  sadc_clk_if cif ();

  sadc_clkdiv u_div (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .cif(cif)
  );

  logic [4:0] acq_clks;
  logic powered;
  logic req;
  logic start;
  logic conv_end;

  assign powered = st_q.cfg[SADC_CFG_MD_LO];
  assign acq_clks = {3'b000, st_q.cfg[SADC_CFG_ACQ_HI:SADC_CFG_ACQ_LO]} + 5'h01;
  assign req = avs_read_i | avs_write_i;
  assign cif.div_sel = st_q.cfg[SADC_CFG_DIV_HI:SADC_CFG_DIV_LO];
  assign cif.run = powered;

  always_comb begin
    st_d = st_q;
    st_d.ack = 1'b0;
    st_d.mem_we = 1'b0;
    st_d.mem_re = 1'b0;
    st_d.sample = 1'b0;
    start = 1'b0;
    conv_end = 1'b0;

    // One wait state per access; the answer comes on the second edge
    if (req && !st_q.ack) begin
      st_d.ack = 1'b1;
      if (avs_read_i) begin
        st_d.rdata = 32'h0;
        unique case (avs_address_i)
          SADC_OFS_CONFIG: st_d.rdata = {24'h0, st_q.cfg};
          SADC_OFS_CHANNEL: st_d.rdata = {24'h0, st_q.chn};
          SADC_OFS_DMA_ADDR: st_d.rdata = {8'h0, st_q.dma_ptr};
          SADC_OFS_STATUS: begin
            st_d.rdata[SADC_STS_BUSY] = st_q.phase != SADC_IDLE;
            st_d.rdata[SADC_STS_DONE] = st_q.done;
            st_d.rdata[SADC_STS_DMA_ACT] = st_q.dma_act;
          end
          default: st_d.rdata = 32'h0;
        endcase
      end
    end
    // Writes land only at the edge where the master sees waitrequest low
    if (avs_write_i && st_q.ack && avs_byteenable_i[0]) begin
      unique case (avs_address_i)
        SADC_OFS_CONFIG: st_d.cfg = avs_writedata_i[7:0];
        SADC_OFS_CHANNEL: begin
          st_d.chn = avs_writedata_i[7:0];
          st_d.chn[SADC_CH_START] = 1'b0;
          start = avs_writedata_i[SADC_CH_START];
        end
        SADC_OFS_DMA_ADDR: st_d.dma_ptr = avs_writedata_i[23:0];
        SADC_OFS_STATUS: begin
          if (avs_writedata_i[SADC_STS_DONE]) begin
            st_d.done = 1'b0;
          end
        end
        default: st_d.cfg = st_q.cfg;
      endcase
    end
    st_d.wreq = !st_d.ack;

    // Conversion sequencer on conversion clock ticks
    if (!powered) begin
      st_d.phase = SADC_IDLE;
      st_d.cnt = 5'h00;
    end else if (cif.tick) begin
      unique case (st_q.phase)
        SADC_IDLE: begin
          if (st_q.stopping) begin
            st_d.phase = SADC_IDLE;
          end
        end
        SADC_ACQ: begin
          if (st_q.cnt >= acq_clks - 5'h01) begin
            st_d.phase = SADC_CONV;
            st_d.cnt = 5'h00;
            st_d.sample = 1'b1;
          end else begin
            st_d.cnt = st_q.cnt + 5'h01;
          end
        end
        SADC_CONV: begin
          if (st_q.cnt >= SADC_APPROX_CLKS - 5'h01) begin
            st_d.phase = SADC_SYNC;
            st_d.cnt = 5'h00;
          end else begin
            st_d.cnt = st_q.cnt + 5'h01;
          end
        end
        SADC_SYNC: begin
          if (st_q.cnt >= SADC_SYNC_CLKS - 5'h01) begin
            conv_end = 1'b1;
            st_d.cnt = 5'h00;
            st_d.phase = SADC_IDLE;
          end else begin
            st_d.cnt = st_q.cnt + 5'h01;
          end
        end
      endcase
    end

    if (conv_end) begin
      st_d.result = adc_result_i;
      st_d.result_vld = 1'b1;
      if (!st_q.dma_act) begin
        st_d.done = 1'b1;
      end
    end

    // Start from software, or chain in continuous or stream mode
    if (powered && st_d.phase == SADC_IDLE && !st_q.stopping) begin
      if ((start && st_q.phase == SADC_IDLE) ||
          (conv_end && (st_q.cfg[SADC_CFG_CONT] || st_q.dma_act))) begin
        st_d.phase = SADC_ACQ;
        st_d.cnt = 5'h00;
        if (start && st_q.chn[SADC_CH_DMA] && !st_q.dma_act) begin
          st_d.dma_act = 1'b1;
          st_d.pipe = 2'h0;
          st_d.mem_addr = st_q.dma_ptr;
          st_d.rd_addr = st_q.dma_ptr;
          st_d.result_vld = 1'b0;
        end
      end
    end

    // Stream pipeline: the first two conversions only fetch next ID; later ones write that conversion's result, then fetch next ID
    if (st_q.dma_act && conv_end) begin
      st_d.conv_id = st_q.next_id;
      st_d.wr_id = st_q.conv_id;
      if (st_q.pipe < SADC_DMA_PIPE_DEPTH - 2'h1) begin
        st_d.pipe = st_q.pipe + 2'h1;
        st_d.mem_re = 1'b1;
        st_d.mem_bus = st_q.rd_addr;
      end else begin
        st_d.mem_we = 1'b1;
        st_d.mem_bus = st_q.mem_addr;
        st_d.mem_wdata = {st_q.conv_id, adc_result_i};
      end
    end
    // Next ID is read the cycle after the write, so the two never share the bus
    if (st_q.mem_we) begin
      if (st_q.mem_addr < SADC_DMA_ADDR_MAX - 24'h000001) begin
        st_d.mem_addr = st_q.mem_addr + 24'h000002;
      end
      st_d.mem_re = 1'b1;
      st_d.mem_bus = st_q.rd_addr;
    end
    if (st_q.mem_re && st_q.dma_act) begin
      st_d.next_id = mem_rdata_i[15:12];
      if (st_q.rd_addr < SADC_DMA_ADDR_MAX - 24'h000001) begin
        st_d.rd_addr = st_q.rd_addr + 24'h000002;
      end
      if (mem_rdata_i[15:12] == SADC_DMA_STOP_ID ||
          st_q.rd_addr >= SADC_DMA_ADDR_MAX - 24'h000002) begin
        st_d.stopping = 1'b1;
      end
    end
    if (st_q.stopping && st_q.phase == SADC_IDLE) begin
      st_d.stopping = 1'b0;
      st_d.dma_act = 1'b0;
      st_d.done = 1'b1;
    end
    st_d.chan = st_d.dma_act ? st_d.conv_id : st_d.chn[SADC_CH_SEL_HI:0];
    st_d.int_ref = st_d.cfg[SADC_CFG_INTREF] & ~st_d.cfg[SADC_CFG_EXTREF];
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= '0;
      st_q.cfg <= SADC_CONFIG_RST;
      st_q.chn <= SADC_CHANNEL_RST;
      st_q.phase <= SADC_IDLE;
      st_q.wreq <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Waitrequest idles high; it drops for the one cycle that completes a request
  assign avs_waitrequest_o = st_q.wreq;
  assign avs_readdata_o = st_q.rdata;
  assign adc_sample_o = st_q.sample;
  assign adc_power_o = st_q.cfg[SADC_CFG_MD_LO];
  assign adc_channel_o = st_q.chan;
  assign ref_ext_sel_o = st_q.cfg[SADC_CFG_EXTREF];
  assign ref_int_en_o = st_q.int_ref;
  assign mem_addr_o = st_q.mem_bus;
  assign mem_wdata_o = st_q.mem_wdata;
  assign mem_write_o = st_q.mem_we;
  assign mem_read_o = st_q.mem_re;
  assign done_flag_o = st_q.done;
endmodule : sadc_top

// File: rtl/sadc_pkg.sv
package sadc_pkg;
  // Avalon-MM register offsets (byte addresses, word aligned)
  localparam logic [3:0] SADC_OFS_CONFIG = 4'h0;
  localparam logic [3:0] SADC_OFS_CHANNEL = 4'h4;
  localparam logic [3:0] SADC_OFS_DMA_ADDR = 4'h8;
  localparam logic [3:0] SADC_OFS_STATUS = 4'hc;
  // Config register fields
  localparam int SADC_CFG_MD_LO = 7;
  localparam int SADC_CFG_EXTREF = 6;
  localparam int SADC_CFG_DIV_HI = 5;
  localparam int SADC_CFG_DIV_LO = 4;
  localparam int SADC_CFG_ACQ_HI = 3;
  localparam int SADC_CFG_ACQ_LO = 2;
  localparam int SADC_CFG_INTREF = 1;
  localparam int SADC_CFG_CONT = 0;
  // Channel and status register fields
  localparam int SADC_CH_DMA = 6;
  localparam int SADC_CH_START = 7;
  localparam int SADC_CH_SEL_HI = 3;
  localparam int SADC_STS_BUSY = 0;
  localparam int SADC_STS_DONE = 1;
  localparam int SADC_STS_DMA_ACT = 2;
  localparam logic [7:0] SADC_CONFIG_RST = 8'h00;
  localparam logic [7:0] SADC_CHANNEL_RST = 8'h00;
  // Conversion clock divide ratios by select code
  localparam logic [5:0] SADC_DIV_00 = 6'h20;
  localparam logic [5:0] SADC_DIV_01 = 6'h04;
  localparam logic [5:0] SADC_DIV_10 = 6'h08;
  localparam logic [5:0] SADC_DIV_11 = 6'h02;
  localparam logic [4:0] SADC_APPROX_CLKS = 5'h0f;
  localparam logic [4:0] SADC_SYNC_CLKS = 5'h01;
  localparam logic [23:0] SADC_DMA_ADDR_MAX = 24'hffffff;
  localparam logic [3:0] SADC_DMA_STOP_ID = 4'hf;
  localparam logic [1:0] SADC_DMA_PIPE_DEPTH = 2'h3;
  localparam int SADC_AW = 4;
  localparam int SADC_MAW = 24;
  typedef enum logic [1:0] {SADC_IDLE, SADC_ACQ, SADC_CONV, SADC_SYNC} sadc_phase_t;
endpackage : sadc_pkg

// File: rtl/sadc_clk_if.sv
`timescale 1ns/1ps
interface sadc_clk_if;
  logic [1:0] div_sel;
  logic run;
  logic tick;
  modport gen (input div_sel, input run, output tick);
  modport use_ (output div_sel, output run, input tick);
endinterface : sadc_clk_if

// File: rtl/sadc_clkdiv.sv
`timescale 1ns/1ps
module sadc_clkdiv (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  sadc_clk_if.gen cif
);
  import sadc_pkg::*;
  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
  } sadc_div_st_t;
  sadc_div_st_t st_q, st_d;
  logic [5:0] ratio;
  always_comb begin
    unique case (cif.div_sel)
      2'b00: ratio = SADC_DIV_00;
      2'b01: ratio = SADC_DIV_01;
      2'b10: ratio = SADC_DIV_10;
      2'b11: ratio = SADC_DIV_11;
    endcase
  end
  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (!cif.run) begin
      st_d.cnt = 6'h00;
    end else if (st_q.cnt >= ratio - 6'h01) begin
      st_d.cnt = 6'h00;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + 6'h01;
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign cif.tick = st_q.tick;
endmodule : sadc_clkdiv

// File: bench/sadc_monitor.sv
`timescale 1ns/1ps
module sadc_monitor (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  input wire logic adc_sample_o,
  input wire logic ref_ext_sel_o,
  input wire logic ref_int_en_o,
  input wire logic mem_write_o,
  input wire logic mem_read_o,
  input wire logic done_flag_o
);
  logic [7:0] cfg_q;
  logic [9:0] cnt_q;
  logic [1:0] smp_q;
  logic cfg_wr;
  logic [5:0] div;
  logic [9:0] per;
  assign cfg_wr = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0 && avs_byteenable_i[0];
  assign div = cfg_q[5:4] == 2'b00 ? 6'h20 : cfg_q[5:4] == 2'b01 ? 6'h04 :
               cfg_q[5:4] == 2'b10 ? 6'h08 : 6'h02;
  assign per = 10'(div) * (10'(cfg_q[3:2]) + 10'h011);
  // Period is only trusted two samples after the last config write
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_q <= 8'h00;
      cnt_q <= 10'h000;
      smp_q <= 2'h0;
    end else begin
      if (cfg_wr) cfg_q <= avs_writedata_i[7:0];
      cnt_q <= adc_sample_o ? 10'h001 : cnt_q + 10'h001;
      if (cfg_wr) smp_q <= 2'h0;
      else if (adc_sample_o && smp_q != 2'h3) smp_q <= smp_q + 2'h1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  a_wait_one_state: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("waitrequest held too long");
  a_conv_period_exact: assert property (adc_sample_o && cfg_q[0] && smp_q >= 2'h2 |-> cnt_q == per)
    else $error("continuous sample period wrong");
  a_sample_one_pulse: assert property (adc_sample_o |=> !adc_sample_o) else $error("sample pulse too long");
  a_ext_ref_follow: assert property (cfg_wr |=> ref_ext_sel_o == $past(avs_writedata_i[6]))
    else $error("external reference select wrong");
  a_int_ref_gate: assert property (cfg_wr |=> ref_int_en_o == ($past(avs_writedata_i[1]) && !$past(avs_writedata_i[6])))
    else $error("internal reference enable wrong");
  a_ref_off_reset: assert property ($rose(resetn_i) |-> !ref_int_en_o) else $error("reference on after reset");
  a_done_sticky_flag: assert property (done_flag_o && !(avs_write_i && avs_address_i == 4'hc) |=> done_flag_o)
    else $error("done flag dropped");
  a_mem_write_pulse: assert property (mem_write_o |=> !mem_write_o) else $error("memory write too long");
  a_mem_rw_excl: assert property (!(mem_write_o && mem_read_o)) else $error("memory read and write together");
  cover property (adc_sample_o && cfg_q[0] && smp_q >= 2'h2);
  cover property ($rose(done_flag_o));
  cover property (mem_write_o);
endmodule : sadc_monitor
bind sadc_top sadc_monitor u_mon (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_waitrequest_o(avs_waitrequest_o), .adc_sample_o(adc_sample_o),
  .ref_ext_sel_o(ref_ext_sel_o), .ref_int_en_o(ref_int_en_o), .mem_write_o(mem_write_o),
  .mem_read_o(mem_read_o), .done_flag_o(done_flag_o));

// File: bench/sadc_sram_model.sv
`timescale 1ns/1ps
module sadc_sram_model (
  input wire logic clk_sys_i,
  input wire logic [23:0] mem_addr_i,
  input wire logic [15:0] mem_wdata_i,
  input wire logic mem_write_i,
  input wire logic mem_read_i,
  output logic [15:0] mem_rdata_o
);
  // Small window only; upper address bits are not decoded
  logic [15:0] mem [0:255];
  logic [15:0] last_q = 16'h0000;
  // Undriven outside reads: show the complement, never a stale value
  assign mem_rdata_o = mem_read_i ? mem[mem_addr_i[7:0]] : ~last_q;
  always @(posedge clk_sys_i) begin
    if (mem_write_i) mem[mem_addr_i[7:0]] <= mem_wdata_i;
    if (mem_read_i) last_q <= mem_rdata_o;
  end
endmodule : sadc_sram_model

// File: bench/sadc_top_tb.sv
`timescale 1ns/1ps
module sadc_top_tb;
  import sadc_pkg::*;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic [11:0] adc_result_i = 12'h000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, adc_sample_o, adc_power_o, ref_ext_sel_o, ref_int_en_o;
  logic mem_write_o, mem_read_o, done_flag_o;
  logic [3:0] adc_channel_o;
  logic [23:0] mem_addr_o;
  logic [15:0] mem_wdata_o, mem_rdata_i;
  int failures = 0;
  int num_checks = 0;
  sadc_top dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .adc_result_i(adc_result_i),
    .adc_sample_o(adc_sample_o), .adc_power_o(adc_power_o), .adc_channel_o(adc_channel_o),
    .ref_ext_sel_o(ref_ext_sel_o), .ref_int_en_o(ref_int_en_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_write_o(mem_write_o), .mem_read_o(mem_read_o),
    .mem_rdata_i(mem_rdata_i), .done_flag_o(done_flag_o));
  sadc_sram_model u_mem (.clk_sys_i(clk_sys_i), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
    .mem_write_i(mem_write_o), .mem_read_i(mem_read_o), .mem_rdata_o(mem_rdata_i));
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    q = avs_readdata_o;
    if (n >= 20) failures++;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask : bus
  task automatic wait_sample(output int n);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (adc_sample_o !== 1'b1 && n < 3000);
  endtask : wait_sample
  function automatic int exp_period(input logic [7:0] c);
    int div;
    div = (c[5:4] == 2'b00) ? 32 : (c[5:4] == 2'b01) ? 4 : (c[5:4] == 2'b10) ? 8 : 2;
    return div * (int'(c[3:2]) + 17);
  endfunction : exp_period
  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    failures++;
    finish_test();
  end
  initial begin
    logic [31:0] rq;
    logic [7:0] c;
    int n, first;
    void'($urandom(32'h790a7f35));
    repeat (5) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    bus(0, SADC_OFS_CONFIG, 0, rq);
    chk(rq, 32'h0);
    chk(ref_int_en_o, 0);
    bus(0, 4'h2, 0, rq);
    chk(rq, 32'h0);
    avs_byteenable_i <= 4'he;
    bus(1, SADC_OFS_CONFIG, 32'h42, rq);
    avs_byteenable_i <= 4'hf;
    @(negedge clk_sys_i);
    chk(ref_ext_sel_o, 0);
    $display("test reset and refusals done");
    repeat (4) begin
      c = 8'($urandom) & 8'h7e;
      bus(1, SADC_OFS_CONFIG, c, rq);
      @(negedge clk_sys_i);
      chk(ref_ext_sel_o, c[6]);
      chk(ref_int_en_o, c[1] & ~c[6]);
      bus(0, SADC_OFS_CONFIG, 0, rq);
      chk(rq, c);
    end
    $display("test reference select done");
    for (int k = 0; k < 4; k++) begin
      c = 8'h81 | 8'(k << 4) | 8'($urandom_range(3) << 2);
      if (k == 0) c = 8'h8d;
      adc_result_i <= 12'($urandom);
      bus(1, SADC_OFS_CONFIG, c, rq);
      bus(1, SADC_OFS_CHANNEL, 32'h80, rq);
      repeat (3) wait_sample(n);
      chk(n, exp_period(c));
      bus(1, SADC_OFS_CONFIG, c & 8'hfe, rq);
      repeat (700) @(posedge clk_sys_i);
    end
    $display("test conversion timing done");
    bus(1, SADC_OFS_STATUS, 32'h2, rq);
    bus(1, SADC_OFS_CHANNEL, 32'h85, rq);
    @(negedge clk_sys_i);
    chk(adc_channel_o, 4'h5);
    for (n = 0; n < 3000 && done_flag_o !== 1'b1; n++) @(posedge clk_sys_i);
    bus(0, SADC_OFS_STATUS, 0, rq);
    chk(rq[1], 1);
    $display("test single conversion done");
    for (int i = 0; i < 256; i++) u_mem.mem[i] = 16'hf000;
    u_mem.mem[8'h10] = 16'h3000;
    u_mem.mem[8'h12] = 16'h5000;
    u_mem.mem[8'h14] = 16'h5000;
    bus(1, SADC_OFS_STATUS, 32'h2, rq);
    bus(1, SADC_OFS_DMA_ADDR, 32'h10, rq);
    bus(1, SADC_OFS_CHANNEL, 32'h40, rq);
    bus(1, SADC_OFS_CONFIG, 32'hb0, rq);
    adc_result_i <= 12'($urandom);
    bus(1, SADC_OFS_CHANNEL, 32'hc0, rq);
    first = -1;
    c = 8'h00;
    for (n = 0; n < 5000 && done_flag_o !== 1'b1; n++) begin
      @(posedge clk_sys_i);
      if (adc_sample_o === 1'b1) c++;
      if (mem_write_o === 1'b1 && first < 0) begin
        first = c;
        rq = {16'h0, mem_wdata_o};
      end
    end
    chk(first >= 3, 1);
    chk(rq, {16'h0, 4'h3, adc_result_i});
    chk(done_flag_o, 1);
    $display("test memory stream done");
    finish_test();
  end
endmodule : sadc_top_tb
